// >>> verilog/round_sched_map.vh
// register offsets, field positions and timing constants of the round scheduler
`ifndef ROUND_SCHED_MAP_VH
`define ROUND_SCHED_MAP_VH
`define RATE_REG_ADDR 6'h20
`define RATE_RESET 8'h02
`define RATE_FIELD_MSB 1
`define RATE_FIELD_LSB 0
`define VCTL_ATE_BIT 5
`define VCTL_EN_LSB 6
`define VCTL_EN_MSB 10
`define CLK_HZ 40000000
`define US_PER_MS 1000
`define MS_PER_S 1000
`define REMOTE_CONV_US 7500
`define LOCAL_CONV_US 7500
`define VOLT_CONV_US 1420
`define REMOTE_CONV_COUNT 2
`define VOLT_CONV_COUNT 5
`define INTERVAL_91_MS 91
`define INTERVAL_182_MS 182
`define INTERVAL_364_MS 364
`define INTERVAL_728_MS 728
`define INTERVAL_1456_MS 1456
`define STEP_REMOTE 3'h0
`define STEP_LOCAL 3'h1
`define STEP_VOLT 3'h2
`endif

// >>> verilog/phase_timer.v
// down counter that times one conversion step and pulses on expiry
`timescale 1ns/1ps
module phase_timer #(
    parameter WIDTH = 32
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    output reg expired,
    output reg busy
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clk) begin
        if (rst) begin
            count_reg <= {WIDTH{1'b0}};
            expired <= 1'b0;
            busy <= 1'b0;
        end else if (load) begin
            count_reg <= load_value;
            expired <= 1'b0;
            busy <= 1'b1;
        end else if (busy && count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            count_reg <= {WIDTH{1'b0}};
            expired <= 1'b1;
            busy <= 1'b0;
        end else begin
            count_reg <= busy ? count_reg - {{(WIDTH-1){1'b0}}, 1'b1}
                              : count_reg;
            expired <= 1'b0;
        end
    end
endmodule // phase_timer

// >>> verilog/conversion_rate_scheduler.v
// conversion round scheduler: rate register, round sequencer, attention
//
// Contract
// - round spacing set by rate code bits 1-0 and the slow-scan select bit
// - codes give continuous/91/182/364 ms, or 91/364/728/1456 ms when slow
// - rate register bits 7-2 are reserved and always read zero
// - rate register resets to code 2, the 182 ms interval, or 728 ms when slow
// - continuous mode runs rounds back to back: 2 remote, local, 5 voltage
// - with attention enabled, one request per round matches master scan
// - attention only if enable bit and at least one voltage channel enabled
`timescale 1ns/1ps
`include "round_sched_map.vh"
module conversion_rate_scheduler #(
    parameter CLK_FREQ_HZ = `CLK_HZ,
    parameter CNT_WIDTH = 32
) (
    input wire CORE_CLK,
    input wire RST,
    input wire REG_WR,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire SLOW_SCAN_SELECT,
    input wire ALERT_REQUEST_ENABLE,
    input wire [4:0] VOLTAGE_CHANNEL_ENABLES,
    output reg [7:0] RATE_RDATA,
    output reg ROUND_START,
    output reg [2:0] CONV_STEP,
    output reg [2:0] CONV_INDEX,
    output reg CONV_ACTIVE,
    output reg ROUND_DONE,
    output reg ATTENTION_REQ
);
    // cycle counts are worked per millisecond, multiplying before dividing,
    // so sub-millisecond steps keep precision and 32 bits never overflow
    localparam [CNT_WIDTH-1:0] CYC_PER_MS = CLK_FREQ_HZ / `MS_PER_S;
    localparam [CNT_WIDTH-1:0] REMOTE_CYC =
        `REMOTE_CONV_US * CYC_PER_MS / `US_PER_MS;
    localparam [CNT_WIDTH-1:0] LOCAL_CYC =
        `LOCAL_CONV_US * CYC_PER_MS / `US_PER_MS;
    localparam [CNT_WIDTH-1:0] VOLT_CYC =
        `VOLT_CONV_US * CYC_PER_MS / `US_PER_MS;
    localparam [CNT_WIDTH-1:0] I91_CYC = `INTERVAL_91_MS * CYC_PER_MS;
    localparam [CNT_WIDTH-1:0] I182_CYC = `INTERVAL_182_MS * CYC_PER_MS;
    localparam [CNT_WIDTH-1:0] I364_CYC = `INTERVAL_364_MS * CYC_PER_MS;
    localparam [CNT_WIDTH-1:0] I728_CYC = `INTERVAL_728_MS * CYC_PER_MS;
    localparam [CNT_WIDTH-1:0] I1456_CYC = `INTERVAL_1456_MS * CYC_PER_MS;
    // only the code field is stored; the rest of the byte reads zero
    localparam [7:0] RATE_RESET_BYTE = `RATE_RESET;

    // one-hot sequencer states
    localparam [3:0] ST_START = 4'h1;
    localparam [3:0] ST_CONV = 4'h2;
    localparam [3:0] ST_NEXT = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    reg [1:0] rate_code_reg;
    reg [1:0] rate_code_next;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [CNT_WIDTH-1:0] interval_reg;
    reg [CNT_WIDTH-1:0] interval_limit_reg;
    reg continuous_reg;
    reg timer_load;
    reg [CNT_WIDTH-1:0] timer_value;
    reg [2:0] load_step;
    wire timer_expired;
    wire interval_up;
    wire rate_hit;
    wire last_conv;

    // control inputs come from the host's register block on this clock
    // writes to any other address belong to other registers and are ignored
    assign rate_hit = REG_WR && REG_ADDR == `RATE_REG_ADDR;

    always @* begin
        rate_code_next = rate_code_reg;
        if (rate_hit) begin
            rate_code_next = REG_WDATA[`RATE_FIELD_MSB:`RATE_FIELD_LSB];
        end
    end

    // read data is registered; a single register needs no address mux
    always @(posedge CORE_CLK) begin
        if (RST) begin
            rate_code_reg <=
                RATE_RESET_BYTE[`RATE_FIELD_MSB:`RATE_FIELD_LSB];
            RATE_RDATA <= `RATE_RESET;
        end else begin
            rate_code_reg <= rate_code_next;
            // reserved bits 7-2 read as zero
            RATE_RDATA <= {6'h00, rate_code_next};
        end
    end

    // the timer loads on the edge that advances the step, so its duration
    // must follow the step being entered rather than the one just ended
    always @* begin
        load_step = CONV_STEP;
        if (state_reg == ST_START) begin
            load_step = `STEP_REMOTE;
        end else if (CONV_STEP == `STEP_REMOTE &&
                CONV_INDEX == `REMOTE_CONV_COUNT - 1) begin
            load_step = `STEP_LOCAL;
        end else if (CONV_STEP == `STEP_LOCAL) begin
            load_step = `STEP_VOLT;
        end
        case (load_step)
            `STEP_REMOTE: timer_value = REMOTE_CYC;
            `STEP_LOCAL: timer_value = LOCAL_CYC;
            default: timer_value = VOLT_CYC;
        endcase
    end

    phase_timer #(
        .WIDTH(CNT_WIDTH)
    ) u_timer (
        .clk(CORE_CLK),
        .rst(RST),
        .load(timer_load),
        .load_value(timer_value),
        .expired(timer_expired),
        .busy()
    );

    // continuous mode ignores the counter; a round that outlasts its
    // interval is followed by the next one at once
    assign interval_up = continuous_reg || interval_reg >= interval_limit_reg;

    // the fifth voltage conversion closes the round
    assign last_conv = CONV_STEP == `STEP_VOLT &&
        CONV_INDEX == `VOLT_CONV_COUNT - 1;

    // each step costs a load and a next cycle on top of its nominal time,
    // so a continuous round runs a few cycles past its nominal length
    always @* begin
        state_next = state_reg;
        timer_load = 1'b0;
        case (state_reg)
            ST_START: begin
                timer_load = 1'b1;
                state_next = ST_CONV;
            end
            ST_CONV: begin
                if (timer_expired) begin
                    state_next = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (last_conv) begin
                    state_next = ST_WAIT;
                end else begin
                    // load the next conversion as the step advances
                    timer_load = 1'b1;
                    state_next = ST_CONV;
                end
            end
            ST_WAIT: begin
                if (interval_up) begin
                    state_next = ST_START;
                end
            end
            default: state_next = ST_START;
        endcase
    end

    // sequencer: the first edge after reset already starts a round
    always @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg <= ST_START;
            CONV_STEP <= `STEP_REMOTE;
            CONV_INDEX <= 3'h0;
            CONV_ACTIVE <= 1'b0;
            ROUND_START <= 1'b0;
            ROUND_DONE <= 1'b0;
            ATTENTION_REQ <= 1'b0;
            interval_reg <= {CNT_WIDTH{1'b0}};
            interval_limit_reg <= I182_CYC;
            continuous_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ROUND_START <= 1'b0;
            ROUND_DONE <= 1'b0;
            ATTENTION_REQ <= 1'b0;
            interval_reg <= interval_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            if (state_reg == ST_START) begin
                // latch the interval once per round so a new code waits
                interval_reg <= {CNT_WIDTH{1'b0}};
                continuous_reg <= !SLOW_SCAN_SELECT &&
                    rate_code_reg == 2'h0;
                case ({SLOW_SCAN_SELECT, rate_code_reg})
                    3'h1: interval_limit_reg <= I91_CYC;
                    3'h2: interval_limit_reg <= I182_CYC;
                    3'h3: interval_limit_reg <= I364_CYC;
                    3'h4: interval_limit_reg <= I91_CYC;
                    3'h5: interval_limit_reg <= I364_CYC;
                    3'h6: interval_limit_reg <= I728_CYC;
                    3'h7: interval_limit_reg <= I1456_CYC;
                    default: interval_limit_reg <= {CNT_WIDTH{1'b0}};
                endcase
                ROUND_START <= 1'b1;
                CONV_ACTIVE <= 1'b1;
                CONV_STEP <= `STEP_REMOTE;
                CONV_INDEX <= 3'h0;
            end else if (state_reg == ST_NEXT) begin
                if (state_next == ST_WAIT) begin
                    CONV_ACTIVE <= 1'b0;
                    ROUND_DONE <= 1'b1;
                    // one request per finished round, at the round rate
                    ATTENTION_REQ <= ALERT_REQUEST_ENABLE &&
                        |VOLTAGE_CHANNEL_ENABLES;
                end else if (CONV_STEP == `STEP_REMOTE &&
                        CONV_INDEX == `REMOTE_CONV_COUNT - 1) begin
                    CONV_STEP <= `STEP_LOCAL;
                    CONV_INDEX <= 3'h0;
                end else if (CONV_STEP == `STEP_LOCAL) begin
                    CONV_STEP <= `STEP_VOLT;
                    CONV_INDEX <= 3'h0;
                end else begin
                    CONV_INDEX <= CONV_INDEX + 3'h1;
                end
            end
        end
    end
endmodule // conversion_rate_scheduler

// >>> tb/rate_sched_checker_assertions.sv
// port-level checks of the conversion round scheduler
`timescale 1ns/1ps
module rate_sched_checker (
    input wire CORE_CLK,
    input wire RST,
    input wire REG_WR,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire ALERT_REQUEST_ENABLE,
    input wire [4:0] VOLTAGE_CHANNEL_ENABLES,
    input wire [7:0] RATE_RDATA,
    input wire ROUND_START,
    input wire [2:0] CONV_STEP,
    input wire [2:0] CONV_INDEX,
    input wire CONV_ACTIVE,
    input wire ROUND_DONE,
    input wire ATTENTION_REQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wire take = REG_WR && REG_ADDR == 6'h20;
    wire due = ALERT_REQUEST_ENABLE && |VOLTAGE_CHANNEL_ENABLES;
    a_reserved_zero: assert property (RATE_RDATA[7:2] == 6'h00)
        else $error("reserved bits set");
    a_write_code: assert property (take |=> RATE_RDATA ==
        {6'h00, $past(REG_WDATA[1:0])}) else $error("code not stored");
    a_reset_code: assert property (disable iff (1'b0) RST |=>
        RATE_RDATA == 8'h02) else $error("bad reset code");
    a_start_first: assert property (ROUND_START |-> CONV_ACTIVE &&
        CONV_STEP == 3'h0 && CONV_INDEX == 3'h0) else $error("bad start");
    a_done_last: assert property (ROUND_DONE |->
        $past(CONV_STEP) == 3'h2 && $past(CONV_INDEX) == 3'h4)
        else $error("done before last step");
    a_active_end: assert property ($fell(CONV_ACTIVE) |->
        ROUND_DONE) else $error("round ended without done");
    a_attn_cause: assert property (ATTENTION_REQ |->
        ROUND_DONE && $past(due)) else $error("stray attention");
    a_attn_due: assert property (ROUND_DONE && $past(due) |->
        ATTENTION_REQ) else $error("missing attention");
endmodule // rate_sched_checker
bind conversion_rate_scheduler rate_sched_checker rate_sched_checker_i (
    .CORE_CLK(CORE_CLK), .RST(RST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .ALERT_REQUEST_ENABLE(ALERT_REQUEST_ENABLE),
    .VOLTAGE_CHANNEL_ENABLES(VOLTAGE_CHANNEL_ENABLES),
    .RATE_RDATA(RATE_RDATA), .ROUND_START(ROUND_START),
    .CONV_STEP(CONV_STEP), .CONV_INDEX(CONV_INDEX),
    .CONV_ACTIVE(CONV_ACTIVE), .ROUND_DONE(ROUND_DONE),
    .ATTENTION_REQ(ATTENTION_REQ));

// >>> tb/scan_master_model.sv
// bus master that services each attention request once
`timescale 1ns/1ps
module scan_master_model (
    input wire clk,
    input wire rst,
    input wire attention_req,
    output int serviced
);
    always @(posedge clk) begin
        if (rst) serviced <= 0;
        else if (attention_req) serviced <= serviced + 1;
    end
endmodule // scan_master_model

// >>> tb/conversion_rate_scheduler_tb_top.sv
// self-checking bench of the conversion round scheduler
`timescale 1ns/1ps
module conversion_rate_scheduler_tb_top;
    localparam int F = 10000;
    // nominal step and round lengths in cycles; each of the eight
    // conversions may add up to three cycles of sequencing overhead
    localparam int t_conv = 7500 * F / 1000000;
    localparam int t_volt = 1420 * F / 1000000;
    localparam int t_round = (3 * 7500 + 5 * 1420) * F / 1000000;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg wr_en = 1'b0;
    reg [5:0] addr = 6'h00;
    reg [7:0] wdata = 8'h00;
    reg slow = 1'b0;
    reg alert = 1'b0;
    reg [4:0] en = 5'h00;
    wire [7:0] rd;
    wire [2:0] step_w, index_w;
    wire start, done, attn, active;
    int serviced, n, e;
    int n_mismatch = 0;
    int n_compared = 0;
    int exp_attn = 0;
    bit due_prev = 1'b0;
    logic [31:0] seed = 32'h00000011;
    int cfg[10] = '{0, 1, 3, 4, 5, 2, 6, 7, 0, 0};
    int span = 0;
    logic [2:0] step_prev = 3'h0;
    conversion_rate_scheduler #(.CLK_FREQ_HZ(F)) conversion_rate_scheduler_i (
        .CORE_CLK(clk), .RST(rst), .REG_WR(wr_en), .REG_ADDR(addr),
        .REG_WDATA(wdata), .SLOW_SCAN_SELECT(slow),
        .ALERT_REQUEST_ENABLE(alert), .VOLTAGE_CHANNEL_ENABLES(en),
        .RATE_RDATA(rd), .ROUND_START(start), .CONV_STEP(step_w),
        .CONV_INDEX(index_w), .CONV_ACTIVE(active), .ROUND_DONE(done),
        .ATTENTION_REQ(attn));
    scan_master_model scan_master_model_i (.clk(clk), .rst(rst),
        .attention_req(attn), .serviced(serviced));
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic cmp_rd(input logic [7:0] x);
        n_compared++;
        if (rd !== x) begin
            n_mismatch++;
            $display("MISMATCH rate_rdata expected %h seen %h", x, rd);
        end
    endtask
    task automatic cmp_int(input string s, input int lo, hi, v);
        n_compared++;
        if (v < lo || v > hi) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", s, lo, hi, v);
        end
    endtask
    // per-step spans, counted in falling edges from the step's first cycle
    always @(negedge clk) begin
        span++;
        if (!rst && step_w != step_prev) begin
            if (step_w == 3'h1)
                cmp_int("remote", 2 * t_conv, 2 * t_conv + 6, span);
            else if (step_w == 3'h2)
                cmp_int("local", t_conv, t_conv + 3, span);
        end
        if (!rst && done === 1'b1)
            cmp_int("voltage", 5 * t_volt, 5 * t_volt + 15, span);
        if (start === 1'b1 || step_w != step_prev || done === 1'b1)
            span = 0;
        step_prev = step_w;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
    endtask
    // sets up the round after the next one, so the count is two rounds late
    task automatic step(input int c);
        n = 2;
        do begin
            @(negedge clk);
            n++;
        end while (start !== 1'b1 && n < 90000);
        exp_attn += due_prev;
        seed = xorshift(seed);
        alert = seed[0];
        en = seed[5:1];
        due_prev = alert && en != 5'h00;
        slow = c[2];
        wr(6'h20, {seed[13:8], c[1:0]});
        cmp_rd({6'h00, c[1:0]});
        cmp_int("attentions", exp_attn, exp_attn, serviced);
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #1200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        int ms[8];
        ms = '{0, 91, 182, 364, 91, 364, 728, 1456};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        cmp_rd(8'h02);
        seed = xorshift(seed);
        wr({1'b0, seed[4:0]}, 8'hFF);
        cmp_rd(8'h02);
        wr(6'h20, 8'hFD);
        cmp_rd(8'h01);
        $display("test register access done");
        for (int i = 0; i < 10; i++) begin
            step(cfg[i]);
            if (i >= 2) begin
                e = ms[cfg[i - 2]] * F / 1000;
                if (e == 0)
                    cmp_int("round gap", t_round, t_round + 24, n);
                else
                    cmp_int("round gap", e - 1, e + 2, n);
            end
            $display("test round %0d done", i);
        end
        close_out();
    end
endmodule // conversion_rate_scheduler_tb_top
